// File: design/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser for asynchronous pins
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // pin in, synchronised level out
  input  wire logic i_pin,
  output var  logic o_level
);

  logic meta_reg;
  logic meta_next;
  logic level_next;

  // first flop feeds only the second one
  always_comb begin
    meta_next  = i_rst_n ? i_pin : RESET_VAL;
    level_next = i_rst_n ? meta_reg : RESET_VAL;
  end

  always_ff @(posedge i_ref_clk) begin
    meta_reg <= meta_next;
    o_level  <= level_next;
  end

endmodule

`default_nettype wire

// File: design/supervisor_pkg.sv
package supervisor_pkg;

  // time base
  localparam int unsigned CLK_HZ              = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS       = 1_000_000_000 / CLK_HZ;

  // pushbutton to reset delay, typical figure
  localparam int unsigned PUSHBUTTON_DELAY_NS = 250;
  localparam int unsigned PUSHBUTTON_DELAY_CYC =
    (PUSHBUTTON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // least kick pulse width, rounded up
  localparam int unsigned KICK_MIN_WIDTH_US   = 1;
  localparam int unsigned KICK_MIN_WIDTH_CYC  =
    (KICK_MIN_WIDTH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // gate settle time, a longest time so rounded down
  localparam int unsigned GATE_SETTLE_US      = 300;
  localparam int unsigned GATE_SETTLE_CYC     = (GATE_SETTLE_US * 1000) / CLK_PERIOD_NS;

  // factory options, plain defaults in cycles
  localparam int unsigned RESET_STRETCH_CYC   = 2000;
  localparam int unsigned STARTUP_DELAY_CYC   = 4000;
  localparam int unsigned KICK_TIMEOUT_CYC    = 3000;
  localparam int unsigned FAULT_PULSE_CYC     = 1000;

  // counter width shared by all timers
  localparam int unsigned CNT_W               = 32;

  // reset values
  localparam logic        RST_N_RESET         = 1'b0;
  localparam logic        FAULT_N_RESET       = 1'b1;

  typedef enum logic [1:0] {
    WD_IDLE    = 2'b00,
    WD_STARTUP = 2'b01,
    WD_WATCH   = 2'b10,
    WD_FAULT   = 2'b11
  } wd_state_t;

endpackage

// File: design/supply_supervisor_watchdog.sv
`timescale 1ns/100ps
`default_nettype none

module supply_supervisor_watchdog #(
  parameter bit          HAS_GATE       = 1'b0,
  parameter int unsigned RESET_STRETCH  = supervisor_pkg::RESET_STRETCH_CYC,
  parameter int unsigned STARTUP_DELAY  = supervisor_pkg::STARTUP_DELAY_CYC,
  parameter int unsigned KICK_TIMEOUT   = supervisor_pkg::KICK_TIMEOUT_CYC,
  parameter int unsigned FAULT_WIDTH    = supervisor_pkg::FAULT_PULSE_CYC,
  parameter int unsigned GATE_SETTLE    = supervisor_pkg::GATE_SETTLE_CYC
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // supply comparator and pushbutton
  input  wire logic i_supply_low,
  input  wire logic i_pushbutton_reset_n,
  input  wire logic i_pushbutton_driven,
  // watchdog inputs
  input  wire logic i_kick_in,
  input  wire logic i_kick_floating,
  input  wire logic i_watchdog_gate,
  // open-drain system reset
  output var  logic o_sys_rst_out,
  output var  logic o_sys_rst_oe,
  output var  logic o_sys_rst_n,
  // open-drain fault pulse
  output var  logic o_fault_pulse_n_out,
  output var  logic o_fault_pulse_n_oe,
  output var  logic o_fault_pulse_n
);

  localparam int unsigned W = supervisor_pkg::CNT_W;

  function automatic logic [W-1:0] cnt_of(input int unsigned n);
    cnt_of = W'(n);
  endfunction

  // synchronised pin levels
  logic supply_low_s;
  logic pb_raw;
  logic pb_s;
  logic kick_s;
  logic float_s;
  logic gate_s;

  // undriven pushbutton reads high through the pull-up
  assign pb_raw = i_pushbutton_driven ? i_pushbutton_reset_n : 1'b1;

  pin_sync #(.RESET_VAL(1'b1)) u_sync_supply (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_pin(i_supply_low), .o_level(supply_low_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_pb (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_pin(pb_raw), .o_level(pb_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sync_kick (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_pin(i_kick_in), .o_level(kick_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sync_float (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_pin(i_kick_floating), .o_level(float_s));
  pin_sync #(.RESET_VAL(1'b0)) u_sync_gate (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_pin(i_watchdog_gate), .o_level(gate_s));

  // ---------------- reset generator ----------------
  logic [W-1:0] pb_delay_reg;
  logic [W-1:0] pb_delay_next;
  logic [W-1:0] stretch_reg;
  logic [W-1:0] stretch_next;
  logic         rst_n_reg;
  logic         rst_n_next;
  logic         cause;

  // pushbutton qualified after its delay, counted from the synchronised level so the sync flops add to it
  always_comb begin
    pb_delay_next = '0;
    if (!pb_s) begin
      pb_delay_next = pb_delay_reg;
      if (pb_delay_reg < cnt_of(supervisor_pkg::PUSHBUTTON_DELAY_CYC)) begin
        pb_delay_next = pb_delay_reg + 1'b1;
      end
    end
    cause = supply_low_s
         || (!pb_s && pb_delay_reg >= cnt_of(supervisor_pkg::PUSHBUTTON_DELAY_CYC));
    stretch_next = stretch_reg;
    rst_n_next   = rst_n_reg;
    if (cause) begin
      stretch_next = '0;
      rst_n_next   = 1'b0;
    end else if (!rst_n_reg) begin
      if (stretch_reg >= cnt_of(RESET_STRETCH) - 1'b1) begin
        rst_n_next = 1'b1;
      end else begin
        stretch_next = stretch_reg + 1'b1;
      end
    end
    if (!i_rst_n) begin
      pb_delay_next = '0;
      stretch_next  = '0;
      rst_n_next    = supervisor_pkg::RST_N_RESET;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    pb_delay_reg <= pb_delay_next;
    stretch_reg  <= stretch_next;
    rst_n_reg    <= rst_n_next;
  end

  // ---------------- kick qualifier ----------------
  logic [W-1:0] low_w_reg;
  logic [W-1:0] low_w_next;
  logic [W-1:0] high_w_reg;
  logic [W-1:0] high_w_next;
  logic         kick_d_reg;
  logic         kick_d_next;
  logic         fall_ok_reg;
  logic         fall_ok_next;
  logic         kick_valid;

  // a falling edge counts once the low it starts has lasted 1 us, and the
  // high before it did too; narrower pulses are dropped as glitches
  always_comb begin
    kick_d_next  = kick_s;
    low_w_next   = kick_s ? '0 : low_w_reg + 1'b1;
    high_w_next  = kick_s ? high_w_reg + 1'b1 : '0;
    fall_ok_next = fall_ok_reg;
    kick_valid   = 1'b0;
    if (kick_d_reg && !kick_s) begin
      fall_ok_next = (high_w_reg >= cnt_of(supervisor_pkg::KICK_MIN_WIDTH_CYC));
    end
    if (!kick_s && fall_ok_reg
        && low_w_reg == cnt_of(supervisor_pkg::KICK_MIN_WIDTH_CYC) - 1'b1) begin
      kick_valid = 1'b1;
    end
    if (low_w_reg == '1) low_w_next = low_w_reg;
    if (high_w_reg == '1) high_w_next = high_w_reg;
    if (!i_rst_n) begin
      kick_d_next  = 1'b1;
      low_w_next   = '0;
      high_w_next  = '0;
      fall_ok_next = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    kick_d_reg  <= kick_d_next;
    low_w_reg   <= low_w_next;
    high_w_reg  <= high_w_next;
    fall_ok_reg <= fall_ok_next;
  end

  // ---------------- watchdog ----------------
  supervisor_pkg::wd_state_t st_reg;
  supervisor_pkg::wd_state_t st_next;
  logic [W-1:0] wd_cnt_reg;
  logic [W-1:0] wd_cnt_next;
  logic [W-1:0] settle_reg;
  logic [W-1:0] settle_next;
  logic         fault_n_reg;
  logic         fault_n_next;
  logic         enabled;
  logic         armed;

  // enable source depends on the variant; in the gate variant the settle window after gate rise holds the WD_WATCH count at zero
  always_comb begin
    enabled = HAS_GATE ? gate_s : !float_s;
    settle_next = enabled ? settle_reg : '0;
    if (enabled && settle_reg < cnt_of(GATE_SETTLE)) begin
      settle_next = settle_reg + 1'b1;
    end
    armed = enabled && (!HAS_GATE || settle_reg >= cnt_of(GATE_SETTLE));
    // settle timer has a single writer, so its reset lives here too
    if (!i_rst_n) begin
      settle_next = '0;
    end
  end

  always_comb begin
    st_next      = st_reg;
    wd_cnt_next  = wd_cnt_reg;
    fault_n_next = 1'b1;
    unique case (st_reg)
      supervisor_pkg::WD_IDLE: begin
        wd_cnt_next = '0;
        if (rst_n_reg) st_next = supervisor_pkg::WD_STARTUP;
      end
      supervisor_pkg::WD_STARTUP: begin
        // kicks ignored here; host should already be toggling
        wd_cnt_next = wd_cnt_reg + 1'b1;
        if (wd_cnt_reg >= cnt_of(STARTUP_DELAY) - 1'b1) begin
          wd_cnt_next = '0;
          st_next     = supervisor_pkg::WD_WATCH;
        end
      end
      supervisor_pkg::WD_WATCH: begin
        if (!armed) begin
          wd_cnt_next = '0;
        end else if (kick_valid) begin
          wd_cnt_next = '0;
        end else if (wd_cnt_reg >= cnt_of(KICK_TIMEOUT) - 1'b1) begin
          wd_cnt_next  = '0;
          fault_n_next = 1'b0;
          st_next      = supervisor_pkg::WD_FAULT;
        end else begin
          wd_cnt_next = wd_cnt_reg + 1'b1;
        end
      end
      supervisor_pkg::WD_FAULT: begin
        // kicks ignored while the pulse is out
        fault_n_next = 1'b0;
        wd_cnt_next  = wd_cnt_reg + 1'b1;
        if (wd_cnt_reg >= cnt_of(FAULT_WIDTH) - 1'b1) begin
          fault_n_next = 1'b1;
          wd_cnt_next  = '0;
          st_next      = supervisor_pkg::WD_WATCH;
        end
      end
    endcase
    // system reset drops the state to WD_IDLE, the count and any fault pulse; kicks are ignored while it is held
    if (!rst_n_reg) begin
      st_next      = supervisor_pkg::WD_IDLE;
      wd_cnt_next  = '0;
      fault_n_next = 1'b1;
    end
    if (!i_rst_n) begin
      st_next      = supervisor_pkg::WD_IDLE;
      wd_cnt_next  = '0;
      fault_n_next = supervisor_pkg::FAULT_N_RESET;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    st_reg      <= st_next;
    wd_cnt_reg  <= wd_cnt_next;
    settle_reg  <= settle_next;
    fault_n_reg <= fault_n_next;
  end

  // open-drain pins: only ever pull low
  always_comb begin
    o_sys_rst_n         = rst_n_reg;
    o_sys_rst_out       = 1'b0;
    o_sys_rst_oe        = !rst_n_reg;
    o_fault_pulse_n     = fault_n_reg;
    o_fault_pulse_n_out = 1'b0;
    o_fault_pulse_n_oe  = !fault_n_reg;
  end

endmodule

`default_nettype wire

// File: tb/host_kicker.sv
`timescale 1ns/100ps
`default_nettype none
module host_kicker (
  // clock
  input  wire logic i_ref_clk,
  // mode
  input  wire logic i_en,
  input  wire logic i_narrow,
  // kick line
  output var  logic o_kick
);
  logic [4:0] ph_reg;
  logic       drive;
  // 24-cycle period, low 12 (qualifies) or 5 (too short); idles high when off
  // mode is taken at the edge, the pin moves one small delay later
  initial begin
    ph_reg = 5'h00;
    o_kick = 1'b1;
    forever begin
      @(posedge i_ref_clk);
      drive = !(i_en && (ph_reg < (i_narrow ? 5'h05 : 5'h0C)));
      ph_reg = (ph_reg == 5'h17) ? 5'h00 : ph_reg + 5'h01;
      #1;
      o_kick = drive;
    end
  end
endmodule
`default_nettype wire

// File: tb/sup_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module sup_chk #(
  parameter int unsigned RESET_STRETCH = 20,
  parameter int unsigned STARTUP_DELAY = 40,
  parameter int unsigned KICK_TIMEOUT  = 30,
  parameter int unsigned FAULT_WIDTH   = 10,
  parameter int unsigned GATE_SETTLE   = 15
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // watched pins
  input wire logic i_supply_low,
  input wire logic i_pushbutton_reset_n,
  input wire logic i_pushbutton_driven,
  input wire logic i_kick_in,
  input wire logic i_watchdog_gate,
  input wire logic o_sys_rst_oe,
  input wire logic o_sys_rst_n,
  input wire logic o_fault_pulse_n_oe,
  input wire logic o_fault_pulse_n
);
  int lo_cnt, hi_cnt, f_cnt, g_cnt, kl_cnt, q_cnt;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // run lengths; q_cnt restarts only on a kick low long enough to qualify
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      {lo_cnt, hi_cnt, f_cnt, g_cnt, kl_cnt, q_cnt} <= '0;
    end else begin
      lo_cnt <= o_sys_rst_n ? 0 : lo_cnt + 1;
      hi_cnt <= o_sys_rst_n ? hi_cnt + 1 : 0;
      f_cnt  <= o_fault_pulse_n ? 0 : f_cnt + 1;
      g_cnt  <= i_watchdog_gate ? g_cnt + 1 : 0;
      kl_cnt <= i_kick_in ? 0 : kl_cnt + 1;
      q_cnt  <= (kl_cnt == supervisor_pkg::KICK_MIN_WIDTH_CYC) ? 0 : q_cnt + 1;
    end
  end
  a_rst_oe_pair: assert property (o_sys_rst_oe == !o_sys_rst_n)
    else $error("reset enable disagrees with reset level");
  a_supply_holds_rst: assert property (i_supply_low [*4] |-> !o_sys_rst_n)
    else $error("reset high while supply low");
  a_pb_holds_rst: assert property
    ((!i_pushbutton_reset_n && i_pushbutton_driven) [*8] |-> !o_sys_rst_n)
    else $error("reset high while pushbutton low");
  a_stretch_min: assert property ($rose(o_sys_rst_n) |-> lo_cnt >= RESET_STRETCH)
    else $error("reset released too early");
  a_fault_oe_pair: assert property (o_fault_pulse_n_oe == !o_fault_pulse_n)
    else $error("fault enable disagrees with fault level");
  a_fault_width: assert property ($rose(o_fault_pulse_n) |-> f_cnt == FAULT_WIDTH)
    else $error("fault pulse width wrong");
  a_startup_gap: assert property
    ($fell(o_fault_pulse_n) |-> hi_cnt >= STARTUP_DELAY + KICK_TIMEOUT)
    else $error("fault too soon after reset release");
  a_kick_quiet: assert property ($fell(o_fault_pulse_n) |-> q_cnt >= KICK_TIMEOUT)
    else $error("fault despite recent kick");
  a_gate_settle: assert property
    ($fell(o_fault_pulse_n) |-> g_cnt >= GATE_SETTLE + KICK_TIMEOUT)
    else $error("fault too soon after gate rise");
endmodule
bind supply_supervisor_watchdog sup_chk #(
  .RESET_STRETCH(RESET_STRETCH),
  .STARTUP_DELAY(STARTUP_DELAY),
  .KICK_TIMEOUT (KICK_TIMEOUT),
  .FAULT_WIDTH  (FAULT_WIDTH),
  .GATE_SETTLE  (GATE_SETTLE)
) sup_chk_i (.*);
`default_nettype wire

// File: tb/supply_supervisor_watchdog_test.sv
`timescale 1ns/100ps
`default_nettype none
module test_supply_supervisor_watchdog;
  logic clk = 0, rst_n = 0, supply_low = 0, pb_n = 1, pb_drv = 1, gate = 1;
  logic kick_en = 1, narrow = 0, kick, sys_rst_n, fault_n;
  logic floating = 0, rst_out, rst_oe, flt_out, flt_oe;
  logic [1:0] note;
  logic [31:0] seed = 32'h09CD;
  logic [1:0] exp_q[$];
  logic [1:0] prev = 2'b01;
  int num_errors = 0, tests_run = 0;
  always #50 clk = ~clk;
  host_kicker host_kicker_i (.i_ref_clk(clk), .i_en(kick_en), .i_narrow(narrow), .o_kick(kick));
  supply_supervisor_watchdog #(.HAS_GATE(1'b1), .RESET_STRETCH(20), .STARTUP_DELAY(40),
    .KICK_TIMEOUT(30), .FAULT_WIDTH(10), .GATE_SETTLE(15)) supply_supervisor_watchdog_i (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_supply_low(supply_low),
    .i_pushbutton_reset_n(pb_n), .i_pushbutton_driven(pb_drv), .i_kick_in(kick),
    .i_kick_floating(floating), .i_watchdog_gate(gate), .o_sys_rst_out(rst_out),
    .o_sys_rst_oe(rst_oe), .o_sys_rst_n(sys_rst_n), .o_fault_pulse_n_out(flt_out),
    .o_fault_pulse_n_oe(flt_oe), .o_fault_pulse_n(fault_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task summarize;
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (e !== g) begin
      num_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // open-drain pins: data always low, enable high exactly while pulling low
  task cmp_pins(input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (e !== g) begin
      num_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // note the next {reset, fault} level, then wait a bounded time for it
  task expect_wait(input logic [1:0] v);
    int k;
    exp_q.push_back(v);
    for (k = 0; k < 500 && {sys_rst_n, fault_n} !== v; k++) tick(1);
    if (k == 500) begin
      num_errors++;
      summarize();
    end
  endtask
  // any change of the outputs must match the oldest note; none left means unexpected
  // looked at on the falling edge, where the registered outputs have settled
  always @(negedge clk) begin
    if (rst_n && {sys_rst_n, fault_n} !== prev) begin
      note = (exp_q.size() == 0) ? ~{sys_rst_n, fault_n} : exp_q.pop_front();
      cmp(note, {sys_rst_n, fault_n});
      cmp_pins({1'b0, !note[1], 1'b0, !note[0]}, {rst_out, rst_oe, flt_out, flt_oe});
    end
    prev <= {sys_rst_n, fault_n};
  end
  initial begin
    tick(3);
    rst_n = 1;
    expect_wait(2'b11);
    tick(200);
    kick_en = 0;
    expect_wait(2'b10);
    expect_wait(2'b11);
    gate = 0;
    kick_en = 0;
    tick(200);
    gate = 1;
    kick_en = 1;
    tick(200);
    narrow = 1;
    expect_wait(2'b10);
    narrow = 0;
    expect_wait(2'b11);
    tick(100);
    supply_low = 1;
    expect_wait(2'b01);
    seed = lfsr(seed);
    floating = seed[7];
    tick(8 + int'(seed[4:0]));
    supply_low = 0;
    expect_wait(2'b11);
    pb_drv = 0;
    pb_n = 0;
    tick(50);
    pb_drv = 1;
    expect_wait(2'b01);
    seed = lfsr(seed);
    floating = seed[7];
    tick(8 + int'(seed[4:0]));
    pb_n = 1;
    expect_wait(2'b11);
    tick(150);
    summarize();
  end
endmodule
`default_nettype wire
